// >>> rtl/seea_consts.svh
// Constants for the serial memory slave and its bus master.
// Assumes a single 20 MHz clock; included by both ends.
//
// Behaviour
// RL1: Master waits powerup delay before any transfer.
// RL2: Busy programming: line released, address not acknowledged.
// RL3: START is falling data, clock high.
// RL4: STOP is rising data, clock high.
// RL5: Data changes only while clock low.
// RL6: Slave address: type code plus two straps.
// RL7: Unconnected strap reads as zero.
// RL8: Address bit zero chooses read or write.
// RL9: Receiver pulls data low on ninth clock.
// RL10: Written bytes acknowledged unless write protected.
// RL11: Read: acknowledge continues, none stops sending.
// RL12: Byte write: address, two offsets, data, STOP.
// RL13: STOP after write starts program cycle.
// RL14: Page write increments six low bits only.
// RL15: Over 64 bytes wraps within page.
// RL16: Polling acknowledged only after program completes.
// RL17: Protect high makes top quarter read only.
// RL18: Protect low allows writes everywhere.
// RL19: Counter holds last address plus one, wraps.
// RL20: Random read: dummy write, repeated START, read.
// RL21: Sequential read increments all address bits.
// RL22: First offset byte high, surplus bit ignored.
`ifndef SEEA_CONSTS_SVH
`define SEEA_CONSTS_SVH

`define SEEA_CLK_NS 50
`define SEEA_T_WRITE_MS 10
`define SEEA_T_PU_MS 1
`define SEEA_WRITE_CYCLES ((`SEEA_T_WRITE_MS * 1000000) / `SEEA_CLK_NS)
`define SEEA_PU_CYCLES ((`SEEA_T_PU_MS * 1000000) / `SEEA_CLK_NS)
`define SEEA_SCL_QUARTER_NS 2500
`define SEEA_SCL_QUARTER_CYCLES (`SEEA_SCL_QUARTER_NS / `SEEA_CLK_NS)

// Device type code; the value is arbitrary.
`define SEEA_DEV_TYPE 5'h0b
`define SEEA_PAGE_BYTES 64
`define SEEA_MEM_BYTES 32768
`define SEEA_PROT_QUARTER 2'h3

`define SEEA_OFF_CTRL 12'h000
`define SEEA_OFF_TXDATA 12'h004
`define SEEA_OFF_STATUS 12'h008
`define SEEA_OFF_RXDATA 12'h00c
`define SEEA_CTRL_GO 0
`define SEEA_CTRL_CMD 2:1
`define SEEA_CTRL_NACK 3
`define SEEA_STAT_BUSY 0
`define SEEA_STAT_ACK 1
`define SEEA_STAT_READY 2

`endif

// >>> rtl/seea_device.sv
// Serial memory slave: condition detection, address match, page write,
// self-timed programming, write protection and reads.
// Assumes pins arrive asynchronously and the master keeps to the protocol.
//
// Implementation choices: the placing of the registers and the pin synchronisers.
`timescale 1ns/1ps
`include "seea_consts.svh"

module seea_device import seea_pkg::*; #(
  parameter int WRITE_CYCLES = `SEEA_WRITE_CYCLES
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset.
  seea_link_if.dev link, // Two-wire link.
  input wire logic strap_select_bit0, // Strap for address bit one.
  input wire logic strap_select_bit1, // Strap for address bit two.
  input wire logic write_protect, // High protects the top quarter.
  output logic prog_busy // High during the program cycle.
);

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_s;
  logic sda_s;
  logic strap1_s;
  logic strap0_s;
  logic wp_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic busy_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 5'h03;
      pin_s2_q <= 5'h03;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      pin_s1_q <= {write_protect, strap_select_bit1, strap_select_bit0, link.sda, link.scl};
      pin_s2_q <= pin_s1_q;
      scl_p_q <= pin_s2_q[0];
      sda_p_q <= pin_s2_q[1];
    end
  end

  assign scl_s = pin_s2_q[0];
  assign sda_s = pin_s2_q[1];
  assign strap0_s = pin_s2_q[2];
  assign strap1_s = pin_s2_q[3];
  assign wp_s = pin_s2_q[4];
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  // START is seen only while no program cycle runs; STOP is always seen.
  assign start_det = ~busy_q & scl_s & scl_p_q & sda_p_q & ~sda_s; // [RL3] [RL5] [RL2]
  assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s; // [RL4] [RL5]

  // ----------------------------------------
  // Byte engine
  // ----------------------------------------
  seea_dev_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic sda_oe_q;
  logic [14:0] addr_q;
  logic [6:0] addr_hi_q;
  logic [7:0] mem_q [`SEEA_MEM_BYTES];
  logic [7:0] mem_rd;
  logic addr_match;
  logic prot;
  logic byte_ok;

  assign mem_rd = mem_q[addr_q];
  // A floating strap is seen as zero by the pad.
  assign addr_match = (rx_q[7:3] == `SEEA_DEV_TYPE)
                      && (rx_q[2:1] == {strap1_s, strap0_s}); // [RL6] [RL7]
  assign prot = wp_s & (addr_q[14:13] == `SEEA_PROT_QUARTER); // [RL17] [RL18]
  assign byte_ok = scl_fall & (cnt_q == 4'h8) & (state_q == SEEA_ST_WDATA) & ~prot;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SEEA_ST_IDLE;
      cnt_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'hff;
      sda_oe_q <= 1'b0;
      addr_q <= 15'h0000;
      addr_hi_q <= 7'h00;
    end else if (stop_det) begin
      state_q <= SEEA_ST_IDLE; // [RL4]
      sda_oe_q <= 1'b0;
    end else if (start_det) begin
      state_q <= SEEA_ST_DEVADR;
      cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (scl_rise) begin
      if (cnt_q < 4'h8) begin
        rx_q <= {rx_q[6:0], sda_s};
        cnt_q <= cnt_q + 4'h1;
      end else if (state_q == SEEA_ST_RDATA && sda_s) begin
        state_q <= SEEA_ST_HOLD; // [RL11]
      end
    end else if (scl_fall) begin
      if (cnt_q == 4'h8) begin
        cnt_q <= 4'h9;
        case (state_q)
          SEEA_ST_DEVADR: begin
            if (addr_match) begin
              sda_oe_q <= 1'b1; // [RL9]
              state_q <= rx_q[0] ? SEEA_ST_RDATA : SEEA_ST_MEMHI; // [RL8]
            end else begin
              state_q <= SEEA_ST_IDLE;
            end
          end
          SEEA_ST_MEMHI: begin
            sda_oe_q <= 1'b1; // [RL10]
            addr_hi_q <= rx_q[6:0]; // [RL22]
            state_q <= SEEA_ST_MEMLO;
          end
          SEEA_ST_MEMLO: begin
            sda_oe_q <= 1'b1; // [RL10]
            addr_q <= {addr_hi_q, rx_q}; // [RL22]
            state_q <= SEEA_ST_WDATA;
          end
          SEEA_ST_WDATA: begin
            if (prot) begin
              state_q <= SEEA_ST_HOLD; // [RL17]
            end else begin
              sda_oe_q <= 1'b1; // [RL10]
              addr_q[5:0] <= addr_q[5:0] + 6'h01; // [RL14] [RL15]
            end
          end
          SEEA_ST_RDATA: begin
            sda_oe_q <= 1'b0; // [RL11]
          end
          default: begin
            sda_oe_q <= 1'b0;
          end
        endcase
      end else if (cnt_q == 4'h9) begin
        cnt_q <= 4'h0;
        if (state_q == SEEA_ST_RDATA) begin
          tx_q <= {mem_rd[6:0], 1'b1};
          sda_oe_q <= ~mem_rd[7];
          addr_q <= addr_q + 15'h0001; // [RL19] [RL21]
        end else begin
          sda_oe_q <= 1'b0;
        end
      end else if (state_q == SEEA_ST_RDATA) begin
        sda_oe_q <= ~tx_q[7]; // [RL5]
        tx_q <= {tx_q[6:0], 1'b1};
      end
    end
  end

  // ----------------------------------------
  // Page buffer
  // ----------------------------------------
  logic [7:0] pbuf_q [`SEEA_PAGE_BYTES];
  logic [`SEEA_PAGE_BYTES-1:0] pvalid_q;
  logic [17:0] wcnt_q;
  logic prog_done;

  assign prog_done = busy_q & (wcnt_q == 18'(WRITE_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pvalid_q <= '0;
    end else if (start_det || prog_done) begin
      pvalid_q <= '0;
    end else if (byte_ok) begin
      pvalid_q[addr_q[5:0]] <= 1'b1; // [RL14]
    end
  end

  // Later bytes at the same offset replace earlier ones.
  always_ff @(posedge pclk) begin
    if (byte_ok) begin
      pbuf_q[addr_q[5:0]] <= rx_q; // [RL15]
    end
  end

  // ----------------------------------------
  // Self-timed program cycle
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      wcnt_q <= 18'h00000;
    end else if (prog_done) begin
      busy_q <= 1'b0; // [RL16]
    end else if (busy_q) begin
      wcnt_q <= wcnt_q + 18'h00001;
    end else if (stop_det && (|pvalid_q)) begin
      busy_q <= 1'b1; // [RL13]
      wcnt_q <= 18'h00000;
    end
  end

  // All buffered bytes reach the array together at the end of the cycle.
  always_ff @(posedge pclk) begin
    if (prog_done) begin
      for (int i = 0; i < `SEEA_PAGE_BYTES; i++) begin
        if (pvalid_q[i]) begin
          mem_q[{addr_q[14:6], 6'(i)}] <= pbuf_q[i]; // [RL13]
        end
      end
    end
  end

  assign link.sda_dev_oe = sda_oe_q; // [RL2]
  assign prog_busy = busy_q;

endmodule : seea_device

// >>> rtl/seea_host.sv
// Two-wire bus master with APB registers: byte-level START, STOP,
// write and read commands issued by software.
// Assumes an APB master on pclk and a slave on the link.
`timescale 1ns/1ps
`include "seea_consts.svh"

module seea_host import seea_pkg::*; #(
  parameter int PU_CYCLES = `SEEA_PU_CYCLES
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset.
  seea_link_if.host link, // Two-wire link.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr // APB error.
);

  // ----------------------------------------
  // Power-up delay and register access
  // ----------------------------------------
  localparam int QUARTER = `SEEA_SCL_QUARTER_CYCLES;
  logic [14:0] pu_cnt_q;
  logic pu_done_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic known;
  logic wr_take;
  logic go;
  logic [7:0] txd_q;
  logic [7:0] rxd_q;
  logic ack_q;
  logic nack_q;
  logic rd_q;
  seea_host_state_t hst_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pu_cnt_q <= 15'h0000;
      pu_done_q <= 1'b0;
    end else if (!pu_done_q) begin
      pu_cnt_q <= pu_cnt_q + 15'h0001;
      pu_done_q <= (pu_cnt_q == 15'(PU_CYCLES - 1)); // [RL1]
    end
  end

  always_comb begin
    known = 1'b1;
    rd_d = 32'h00000000;
    case (paddr)
      `SEEA_OFF_CTRL: rd_d = 32'h00000000;
      `SEEA_OFF_TXDATA: rd_d = {24'h000000, txd_q};
      `SEEA_OFF_STATUS: rd_d = {29'h00000000, pu_done_q, ack_q, hst_q != SEEA_H_IDLE};
      `SEEA_OFF_RXDATA: rd_d = {24'h000000, rxd_q};
      default: known = 1'b0;
    endcase
  end

  assign wr_take = psel & penable & pready_q & pwrite;
  // Commands are refused while a command runs or before power-up ends.
  assign go = wr_take & (paddr == `SEEA_OFF_CTRL) & pwdata[`SEEA_CTRL_GO]
              & (hst_q == SEEA_H_IDLE) & pu_done_q; // [RL1]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      if (psel && penable && !pready_q) begin
        prdata_q <= rd_d;
        pslverr_q <= ~known;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_q <= 8'h00;
    end else if (wr_take && paddr == `SEEA_OFF_TXDATA) begin
      txd_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // Link clock divider and bit engine
  // ----------------------------------------
  logic [5:0] qcnt_q;
  logic tick;
  logic [1:0] ph_q;
  logic [3:0] bitn_q;
  logic [7:0] sh_q;
  logic scl_q;
  logic sda_oe_q;
  logic sda_s1_q;
  logic sda_s2_q;

  assign tick = (qcnt_q == 6'(QUARTER - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcnt_q <= 6'h00;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      qcnt_q <= tick ? 6'h00 : qcnt_q + 6'h01;
      sda_s1_q <= link.sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hst_q <= SEEA_H_IDLE;
      ph_q <= 2'h0;
      bitn_q <= 4'h0;
      sh_q <= 8'hff;
      scl_q <= 1'b1;
      sda_oe_q <= 1'b0;
      ack_q <= 1'b0;
      rxd_q <= 8'h00;
      nack_q <= 1'b0;
      rd_q <= 1'b0;
    end else if (go) begin
      ph_q <= 2'h0;
      bitn_q <= 4'h0;
      nack_q <= pwdata[`SEEA_CTRL_NACK];
      rd_q <= (pwdata[`SEEA_CTRL_CMD] == SEEA_CMD_READ);
      sh_q <= (pwdata[`SEEA_CTRL_CMD] == SEEA_CMD_WRITE) ? txd_q : 8'hff;
      case (pwdata[`SEEA_CTRL_CMD])
        SEEA_CMD_START: hst_q <= SEEA_H_START;
        SEEA_CMD_STOP: hst_q <= SEEA_H_STOP;
        default: hst_q <= SEEA_H_BIT;
      endcase
    end else if (tick && hst_q != SEEA_H_IDLE) begin
      ph_q <= ph_q + 2'h1;
      case (hst_q)
        SEEA_H_START: begin
          case (ph_q)
            2'h0: begin
              scl_q <= 1'b0;
              sda_oe_q <= 1'b0;
            end
            2'h1: scl_q <= 1'b1;
            2'h2: sda_oe_q <= 1'b1; // [RL3]
            default: begin
              scl_q <= 1'b0;
              hst_q <= SEEA_H_IDLE;
            end
          endcase
        end
        SEEA_H_STOP: begin
          case (ph_q)
            2'h0: begin
              scl_q <= 1'b0;
              sda_oe_q <= 1'b1;
            end
            2'h1: scl_q <= 1'b1;
            2'h2: sda_oe_q <= 1'b0; // [RL4]
            default: hst_q <= SEEA_H_IDLE;
          endcase
        end
        default: begin
          case (ph_q)
            2'h0: begin
              scl_q <= 1'b0;
              // Data is set up only while the clock is low.
              sda_oe_q <= (bitn_q == 4'h8) ? (rd_q & ~nack_q) : ~sh_q[7]; // [RL5] [RL9] [RL11]
            end
            2'h1: scl_q <= 1'b1;
            2'h2: begin
              if (bitn_q == 4'h8) begin
                ack_q <= ~sda_s2_q;
                rxd_q <= sh_q;
              end else begin
                sh_q <= {sh_q[6:0], sda_s2_q};
              end
            end
            default: begin
              scl_q <= 1'b0;
              bitn_q <= bitn_q + 4'h1;
              if (bitn_q == 4'h8) begin
                hst_q <= SEEA_H_IDLE;
              end
            end
          endcase
        end
      endcase
    end
  end

  assign link.scl = scl_q;
  assign link.sda_host_oe = sda_oe_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule : seea_host

// >>> rtl/seea_link_if.sv
// Two-wire link between the bus master and the memory slave.
// Assumes both ends pull the data line low only through their enables.
`timescale 1ns/1ps
interface seea_link_if;
  logic scl;
  logic sda_host_oe;
  logic sda_dev_oe;
  logic sda;

  // Open-drain data line: low while either end pulls it.
  assign sda = ~(sda_host_oe | sda_dev_oe);

  modport host (output scl, output sda_host_oe, input sda);
  modport dev (input scl, input sda, output sda_dev_oe);
endinterface : seea_link_if

// >>> rtl/seea_pkg.sv
// Types shared by the serial memory slave and its bus master.
// Assumes nothing of its surroundings.
package seea_pkg;

  typedef enum logic [2:0] {
    SEEA_ST_IDLE = 3'h0,
    SEEA_ST_DEVADR = 3'h1,
    SEEA_ST_MEMHI = 3'h3,
    SEEA_ST_MEMLO = 3'h2,
    SEEA_ST_WDATA = 3'h6,
    SEEA_ST_RDATA = 3'h7,
    SEEA_ST_HOLD = 3'h5
  } seea_dev_state_t;

  typedef enum logic [1:0] {
    SEEA_H_IDLE = 2'h0,
    SEEA_H_START = 2'h1,
    SEEA_H_BIT = 2'h3,
    SEEA_H_STOP = 2'h2
  } seea_host_state_t;

  typedef enum logic [1:0] {
    SEEA_CMD_START = 2'h0,
    SEEA_CMD_WRITE = 2'h1,
    SEEA_CMD_READ = 2'h2,
    SEEA_CMD_STOP = 2'h3
  } seea_cmd_t;

endpackage : seea_pkg

// >>> verification/seea_checker.sv
// Checker for the two-wire link between the bus master and the memory slave.
// Assumes it sits beside the link interface, on the same clock and reset.
`timescale 1ns/1ps
module seea_checker #(
  parameter int WRITE_CYCLES = 200
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset.
  input wire logic scl, // Link clock.
  input wire logic sda_host_oe, // Master pulls data low.
  input wire logic sda_dev_oe, // Slave pulls data low.
  input wire logic sda, // Resolved data line.
  input wire logic prog_busy // Program cycle running.
);
  logic [31:0] busy_cnt_q;
  logic sda_q;
  logic seen_start_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ------
  // Helpers
  // ------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt_q <= 32'h0;
    end else if (prog_busy) begin
      busy_cnt_q <= busy_cnt_q + 32'h1;
    end else begin
      busy_cnt_q <= 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_q <= 1'b1;
      seen_start_q <= 1'b0;
    end else begin
      sda_q <= sda;
      if (scl && sda_q && !sda) begin
        seen_start_q <= 1'b1;
      end
    end
  end

  // ------
  // Assertions
  // ------
  chk_busy_release: assert property (prog_busy |-> !sda_dev_oe)
    else $error("slave drives data while programming");
  chk_busy_bound: assert property (prog_busy |-> busy_cnt_q < 32'(WRITE_CYCLES))
    else $error("program cycle runs too long");
  chk_busy_length: assert property ($fell(prog_busy) |-> busy_cnt_q == 32'(WRITE_CYCLES))
    else $error("program cycle length wrong");
  chk_busy_after_stop: assert property ($rose(prog_busy) |-> scl && sda)
    else $error("program cycle began without stop");
  chk_dev_low_scl: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("slave changed data while clock high");
  chk_dev_holds_bit: assert property ($rose(sda_dev_oe) |->
    sda_dev_oe throughout (##[1:200] $rose(scl)))
    else $error("slave low bit not held over clock high");
  chk_host_start_hold: assert property (scl && $rose(sda_host_oe) |-> scl [*8])
    else $error("master start not held with clock high");
  chk_stop_quiet: assert property (scl && $rose(sda) |-> !sda_dev_oe [*8])
    else $error("slave drove data after stop");
  chk_no_start: assert property (!seen_start_q |-> !sda_dev_oe)
    else $error("slave drove data before any start");
endmodule : seea_checker

// >>> verification/tb_serial_eeprom_slave_access.sv
// Bench for the bus master and the memory slave joined by their link.
// Assumes the master's register map and a 20 MHz clock.
`timescale 1ns/1ps
`include "seea_consts.svh"
module tb_serial_eeprom_slave_access import seea_pkg::*; ();
  localparam int WC = 4000;
  localparam logic [7:0] SA_W = {`SEEA_DEV_TYPE, 2'b01, 1'b0};
  localparam logic [7:0] SA_R = {`SEEA_DEV_TYPE, 2'b01, 1'b1};
  localparam logic [7:0] SA_X = {`SEEA_DEV_TYPE, 2'b10, 1'b0};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic strap_select_bit0, strap_select_bit1, write_protect, prog_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] q;
  int failures = 0;
  int num_checks = 0;

  seea_link_if i_seea_link_if ();
  seea_device #(.WRITE_CYCLES(WC)) i_seea_device (.pclk(pclk), .presetn(presetn),
    .link(i_seea_link_if.dev), .strap_select_bit0(strap_select_bit0),
    .strap_select_bit1(strap_select_bit1), .write_protect(write_protect),
    .prog_busy(prog_busy));
  seea_host #(.PU_CYCLES(50)) i_seea_host (.pclk(pclk), .presetn(presetn),
    .link(i_seea_link_if.host), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  seea_checker #(.WRITE_CYCLES(WC)) i_seea_checker (.pclk(pclk), .presetn(presetn),
    .scl(i_seea_link_if.scl), .sda_host_oe(i_seea_link_if.sda_host_oe),
    .sda_dev_oe(i_seea_link_if.sda_dev_oe), .sda(i_seea_link_if.sda),
    .prog_busy(prog_busy));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ------
  // Tasks
  // ------
  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_up(input string what);
    check(what, 32'h0, 32'h1);
    end_of_test();
  endtask : give_up

  // Holds the request until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) give_up("pready");
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic poll(input int b, input logic v);
    int n;
    for (n = 0; n < 3000; n++) begin
      apb(1'b0, `SEEA_OFF_STATUS, 32'h0);
      if (q[b] === v) break;
    end
    if (n == 3000) give_up("status");
  endtask : poll

  task automatic cmd(input seea_cmd_t c, input logic nack);
    apb(1'b1, `SEEA_OFF_CTRL, {28'h0, nack, c, 1'b1});
    poll(`SEEA_STAT_BUSY, 1'b0);
  endtask : cmd

  task automatic st();
    cmd(SEEA_CMD_START, 1'b0);
  endtask : st

  task automatic sp();
    cmd(SEEA_CMD_STOP, 1'b0);
  endtask : sp

  task automatic put(input logic [7:0] b, input logic ack);
    apb(1'b1, `SEEA_OFF_TXDATA, {24'h0, b});
    cmd(SEEA_CMD_WRITE, 1'b0);
    apb(1'b0, `SEEA_OFF_STATUS, 32'h0);
    check("ack", 32'(q[`SEEA_STAT_ACK]), 32'(ack));
  endtask : put

  task automatic get(input logic nack, input logic [7:0] exp);
    cmd(SEEA_CMD_READ, nack);
    apb(1'b0, `SEEA_OFF_RXDATA, 32'h0);
    check("rxdata", q, {24'h0, exp});
  endtask : get

  task automatic wait_idle();
    int n;
    for (n = 0; n < 10000; n++) begin
      @(negedge pclk);
      if (prog_busy === 1'b0) break;
    end
    if (n == 10000) give_up("prog_busy");
  endtask : wait_idle

  task automatic wr(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] d);
    st();
    put(SA_W, 1'b1);
    put(hi, 1'b1);
    put(lo, 1'b1);
    put(d, 1'b1);
    sp();
    wait_idle();
  endtask : wr

  task automatic rd_at(input logic [7:0] hi, input logic [7:0] lo);
    st();
    put(SA_W, 1'b1);
    put(hi, 1'b1);
    put(lo, 1'b1);
    st();
    put(SA_R, 1'b1);
  endtask : rd_at

  // ------
  // Sequence
  // ------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    strap_select_bit0 = 1'b1;
    strap_select_bit1 = 1'b0;
    write_protect = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    check("idle line", 32'({i_seea_link_if.scl, i_seea_link_if.sda}), 32'h3);
    apb(1'b0, 12'h010, 32'h0);
    check("slverr", 32'(pslverr), 32'h1);
    check("unmapped", q, 32'h0);
    poll(`SEEA_STAT_READY, 1'b1);
    $display("test reset done");
    st();
    put(SA_X, 1'b0);
    sp();
    st();
    put(SA_W, 1'b1);
    put(8'h81, 1'b1);
    put(8'h3f, 1'b1);
    put(8'h11, 1'b1);
    put(8'h22, 1'b1);
    put(8'h33, 1'b1);
    sp();
    check("busy", 32'(prog_busy), 32'h1);
    st();
    put(SA_W, 1'b0);
    sp();
    wait_idle();
    $display("test page write done");
    wr(8'hff, 8'hff, 8'ha5);
    wr(8'h80, 8'h00, 8'h3c);
    rd_at(8'h01, 8'h00);
    get(1'b1, 8'h22);
    sp();
    st();
    put(SA_R, 1'b1);
    get(1'b1, 8'h33);
    sp();
    rd_at(8'h7f, 8'hff);
    get(1'b0, 8'ha5);
    get(1'b1, 8'h3c);
    sp();
    $display("test reads done");
    write_protect <= 1'b1;
    st();
    put(SA_W, 1'b1);
    put(8'h60, 1'b1);
    put(8'h00, 1'b1);
    put(8'h99, 1'b0);
    sp();
    check("busy", 32'(prog_busy), 32'h0);
    $display("test protect done");
    end_of_test();
  end
endmodule : tb_serial_eeprom_slave_access
